// ---- core/rsc_pkg.sv ----
// Constants, register map and types of the reset controller
// Behaviour
// - Reset comes from the pin, software request, watchdog overflow, or power-on/low voltage.
// - Writing one to the soft reset request bit starts a software reset.
// - Pin low is synchronised to the system clock, then noise filtered before use.
// - A pin reset puts port and peripheral pins into reset state asynchronously.
// - An uncleared watchdog timeout raises a watchdog reset.
// - Software or watchdog reset lasts one pre-reset cycle plus two cycles at clock/32.
// - RAM protection adds one pre-reset cycle; oscillator standby adds the oscillation wait.
// - Power-on or low-voltage reset holds reset through the whole oscillation wait.
// - Reset-output variants drive the pin low on internal resets only, never on pin reset.
// - Any reset source makes the CPU drop its work and wait at once.
// - After release the CPU performs a mode fetch of mode data and vector.
// - Mode fetch waits for main oscillator settling, and oscillation after power-up/sub/stop.
// - Except on power-on/low voltage, a RAM access in progress completes before the internal reset asserts.
// - Pins stay high impedance from reset until software configures them.
// - Cause bits 7 to 5 read zero and ignore writes.
// - Pin flag bit 4 set by pin reset, kept otherwise, cleared by read.
// - Watchdog flag bit 3 set by watchdog reset, kept otherwise, cleared by read.
// - Power-on flag bit 2 set by power-on reset, kept otherwise, cleared by read.
// - Hardware flag bit 1 set by every non-software reset, cleared by read.
// - Software flag bit 0 set by software reset, cleared by read or power-on.
// - After power-on the cause shows power-on and hardware set, software clear.
// - Oscillation wait setting is reinitialised only by power-on reset.
package rsc_pkg;

  // Register byte offsets
  localparam logic [3:0] RSC_ADR_CAUSE = 4'h0;
  localparam logic [3:0] RSC_ADR_STBY  = 4'h4;
  localparam logic [3:0] RSC_ADR_WAIT  = 4'h8;

  // Cause register field positions
  localparam int RSC_BIT_PIN = 4;
  localparam int RSC_BIT_WDT = 3;
  localparam int RSC_BIT_PON = 2;
  localparam int RSC_BIT_HWR = 1;
  localparam int RSC_BIT_SWR = 0;

  // Standby control field and wait register layout
  localparam int         RSC_BIT_SOFT_REQ = 0;
  localparam int         RSC_WAIT_W       = 4;
  localparam logic [3:0] RSC_WAIT_RST     = 4'hf;

  // Timing
  localparam int          RSC_CLK_MHZ       = 40;
  localparam logic [4:0]  RSC_INIT_DIV_LAST = 5'h1f;
  localparam logic [1:0]  RSC_INIT_CYCLES   = 2'h2;
  localparam int          RSC_CR_WAIT_NS    = 10000;
  localparam logic [15:0] RSC_CR_WAIT_CYC   = 16'((RSC_CR_WAIT_NS * RSC_CLK_MHZ + 999) / 1000);
  localparam int          RSC_OSC_UNIT_CYC  = 256;
  localparam int          RSC_FILT_MIN      = 4;

  typedef enum logic [2:0] {
    RSC_RUN   = 3'b000,
    RSC_DEFER = 3'b001,
    RSC_PRE   = 3'b010,
    RSC_EXTH  = 3'b011,
    RSC_INIT  = 3'b100,
    RSC_OSCW  = 3'b101,
    RSC_CRW   = 3'b110,
    RSC_FETCH = 3'b111
  } rsc_state_t;

  typedef enum logic [1:0] {
    RSC_SRC_SW  = 2'b00,
    RSC_SRC_WDT = 2'b01,
    RSC_SRC_EXT = 2'b10,
    RSC_SRC_PON = 2'b11
  } rsc_src_t;

endpackage

// ---- core/rsc_reset_ctrl.sv ----
// Reset sequencer, cause flags and pin control
`timescale 1ns/1ps
module rsc_reset_ctrl import rsc_pkg::*; #(
  parameter bit HAS_RST_OUT = 1'b1,
  parameter int FILT_MIN    = RSC_FILT_MIN,
  parameter int OSC_UNIT    = RSC_OSC_UNIT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ext_rst_n_i,
  input  wire logic       lvd_i,
  input  wire logic       wdt_ovf_i,
  input  wire logic       ram_busy_i,
  input  wire logic       mclk_en_i,
  input  wire logic       osc_stby_i,
  input  wire logic       sub_stop_i,
  input  wire logic       fetch_done_i,
  input  wire logic       pin_cfg_i,
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [3:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  output logic            ack_o,
  output logic            core_rst_o,
  output logic            cpu_halt_o,
  output logic            fetch_req_o,
  output logic            pins_hiz_o,
  output logic            rst_pin_o,
  output logic            rst_pin_oe_n_o
);

  // Pin synchronisers and noise filter
  logic       ext_meta, ext_sync, lvd_meta, lvd_sync;
  logic [7:0] filt_cnt, next_filt_cnt;
  logic       ext_lvl;

  always_comb begin
    next_filt_cnt = filt_cnt;
    if (ext_sync) begin
      next_filt_cnt = 8'h00;
    end else if (filt_cnt != 8'(FILT_MIN)) begin
      next_filt_cnt = filt_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
      lvd_meta <= 1'b0;
      lvd_sync <= 1'b0;
      filt_cnt <= 8'h00;
    end else begin
      ext_meta <= ext_rst_n_i;
      ext_sync <= ext_meta;
      lvd_meta <= lvd_i;
      lvd_sync <= lvd_meta;
      filt_cnt <= next_filt_cnt;
    end
  end

  // Short lows never reach the count, so they cannot reset the core
  assign ext_lvl = (filt_cnt == 8'(FILT_MIN));

  // Sequencer
  rsc_state_t state, next_state;
  rsc_src_t   kind, next_kind;
  logic [15:0] cnt, next_cnt;
  logic [4:0]  div, next_div;
  logic        init_en;
  logic        sw_req;
  logic        ev_pin, ev_wdt, ev_pon, ev_sw;
  logic        next_core_rst, next_halt, next_fetch, next_oe_n;
  logic        hiz, next_hiz;
  logic [RSC_WAIT_W-1:0] osc_wait_time_register, next_osc_wait_time_register;
  logic [15:0] osc_last;

  assign init_en  = (div == RSC_INIT_DIV_LAST);
  assign osc_last = 16'((32'(osc_wait_time_register) + 32'd1) * 32'(OSC_UNIT) - 32'd1);

  always_comb begin
    next_state = state;
    next_kind  = kind;
    next_cnt   = cnt;
    next_div   = div + 5'h01;
    ev_pin     = 1'b0;
    ev_wdt     = 1'b0;
    ev_pon     = 1'b0;
    ev_sw      = 1'b0;
    // Source priority: power-on, pin, watchdog, software
    if (lvd_sync) begin
      next_state = RSC_OSCW;
      next_kind  = RSC_SRC_PON;
      next_cnt   = 16'h0000;
      ev_pon     = 1'b1;
    end else if (ext_lvl && !(kind == RSC_SRC_EXT &&
                 (state == RSC_DEFER || state == RSC_EXTH))) begin
      next_state = ram_busy_i ? RSC_DEFER : RSC_EXTH;
      next_kind  = RSC_SRC_EXT;
      ev_pin     = 1'b1;
    end else if (wdt_ovf_i || sw_req) begin
      next_state = ram_busy_i ? RSC_DEFER : RSC_PRE;
      next_kind  = wdt_ovf_i ? RSC_SRC_WDT : RSC_SRC_SW;
      ev_wdt     = wdt_ovf_i;
      ev_sw      = !wdt_ovf_i;
    end else begin
      unique case (state)
        RSC_RUN: begin
        end
        RSC_DEFER: begin
          // Access done, then one pre-reset machine cycle more, or straight to the pin hold for a pin reset
          if (!ram_busy_i && mclk_en_i) begin
            next_state = (kind == RSC_SRC_EXT) ? RSC_EXTH : RSC_PRE;
          end
        end
        RSC_PRE: begin
          if (mclk_en_i) begin
            // Restart the divider so both initial-rate cycles are whole
            next_state = RSC_INIT;
            next_cnt   = 16'h0000;
            next_div   = 5'h00;
          end
        end
        RSC_EXTH: begin
          if (!ext_lvl) begin
            next_state = RSC_INIT;
            next_cnt   = 16'h0000;
            next_div   = 5'h00;
          end
        end
        RSC_INIT: begin
          if (init_en) begin
            next_cnt = cnt + 16'h0001;
            if (cnt[1:0] == RSC_INIT_CYCLES - 2'h1) begin
              next_state = (osc_stby_i || sub_stop_i) ? RSC_OSCW : RSC_CRW;
              next_cnt   = 16'h0000;
            end
          end
        end
        RSC_OSCW: begin
          next_cnt = cnt + 16'h0001;
          if (cnt >= osc_last) begin
            next_state = RSC_CRW;
            next_cnt   = 16'h0000;
          end
        end
        RSC_CRW: begin
          next_cnt = cnt + 16'h0001;
          if (cnt >= RSC_CR_WAIT_CYC - 16'h0001) begin
            next_state = RSC_FETCH;
            next_cnt   = 16'h0000;
          end
        end
        RSC_FETCH: begin
          if (fetch_done_i) begin
            next_state = RSC_RUN;
          end
        end
      endcase
    end
    next_core_rst = (next_state == RSC_PRE) || (next_state == RSC_EXTH) ||
                    (next_state == RSC_INIT) || (next_state == RSC_OSCW);
    next_halt     = (next_state != RSC_RUN);
    next_fetch    = (next_state == RSC_FETCH);
    next_oe_n     = !(HAS_RST_OUT && next_core_rst && next_kind != RSC_SRC_EXT);
    next_hiz      = hiz;
    if (next_core_rst) begin
      next_hiz = 1'b1;
    end else if (pin_cfg_i && next_state == RSC_RUN) begin
      next_hiz = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= RSC_OSCW;
      kind        <= RSC_SRC_PON;
      cnt         <= 16'h0000;
      div         <= 5'h00;
      core_rst_o  <= 1'b1;
      cpu_halt_o  <= 1'b1;
      fetch_req_o <= 1'b0;
      hiz         <= 1'b1;
      rst_pin_oe_n_o <= !HAS_RST_OUT;
    end else begin
      state       <= next_state;
      kind        <= next_kind;
      cnt         <= next_cnt;
      div         <= next_div;
      core_rst_o  <= next_core_rst;
      cpu_halt_o  <= next_halt;
      fetch_req_o <= next_fetch;
      hiz         <= next_hiz;
      rst_pin_oe_n_o <= next_oe_n;
    end
  end

  // Raw pin bypasses the synchroniser on purpose: pins must go safe without a clock
  assign pins_hiz_o = hiz || !ext_rst_n_i;
  assign rst_pin_o  = 1'b0;

  // Wishbone registers
  logic [4:0]  cause, next_cause;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        bus_req, rd_cause;

  assign bus_req  = cyc_i && stb_i && !ack_o;
  assign rd_cause = bus_req && !we_i && (adr_i == RSC_ADR_CAUSE);
  assign sw_req   = bus_req && we_i && (adr_i == RSC_ADR_STBY) && sel_i[0] &&
                    dat_i[RSC_BIT_SOFT_REQ];

  always_comb begin
    next_ack   = bus_req;
    next_dat   = 32'h0000_0000;
    next_cause = cause;
    next_osc_wait_time_register  = osc_wait_time_register;
    if (rd_cause) begin
      next_cause = 5'h00;
    end
    if (bus_req && !we_i) begin
      unique case (adr_i)
        RSC_ADR_CAUSE: next_dat = {27'h0000000, cause};
        RSC_ADR_WAIT:  next_dat = {28'h0000000, osc_wait_time_register};
        default:       next_dat = 32'h0000_0000;
      endcase
    end
    if (bus_req && we_i && adr_i == RSC_ADR_WAIT && sel_i[0]) begin
      next_osc_wait_time_register = dat_i[RSC_WAIT_W-1:0];
    end
    // Events win over a same-cycle read clear
    if (ev_pin) begin
      next_cause[RSC_BIT_PIN] = 1'b1;
    end
    if (ev_wdt) begin
      next_cause[RSC_BIT_WDT] = 1'b1;
    end
    if (ev_pon) begin
      next_cause[RSC_BIT_PON] = 1'b1;
      next_cause[RSC_BIT_SWR] = 1'b0;
      next_osc_wait_time_register               = RSC_WAIT_RST;
    end
    if (ev_pin || ev_wdt || ev_pon) begin
      next_cause[RSC_BIT_HWR] = 1'b1;
    end
    if (ev_sw) begin
      next_cause[RSC_BIT_SWR] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause <= 5'h06;
      osc_wait_time_register  <= RSC_WAIT_RST;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      cause <= next_cause;
      osc_wait_time_register  <= next_osc_wait_time_register;
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic quiet;
  assign quiet = !lvd_sync && !ext_lvl && !wdt_ovf_i;

  sequence s_soft_write;
    sw_req && quiet && !ram_busy_i;
  endsequence

  sequence s_pre_then_init;
    state == RSC_PRE ##1 state == RSC_INIT;
  endsequence

  chk_soft_req_start: assert property (s_soft_write |=> state == RSC_PRE)
    else $error("soft request did not start reset");
  chk_pre_one_mcyc: assert property (
      state == RSC_PRE && mclk_en_i && quiet && !sw_req |=> state == RSC_INIT)
    else $error("pre-reset cycle not one machine cycle");
  chk_init_two_cyc: assert property (
      state == RSC_INIT && init_en && cnt == 16'h0001 && quiet && !sw_req
      |=> state != RSC_INIT && state != RSC_RUN)
    else $error("initial rate phase wrong length");
  chk_pre_rst_seq: assert property (s_pre_then_init |-> core_rst_o)
    else $error("reset dropped across pre and init");
  chk_ram_defer: assert property (state == RSC_DEFER |-> !core_rst_o)
    else $error("internal reset during ram access");
  chk_defer_hold: assert property (
      state == RSC_DEFER && ram_busy_i && quiet && !sw_req |=> state == RSC_DEFER)
    else $error("defer left while ram busy");
  chk_pin_no_drive: assert property (kind == RSC_SRC_EXT |-> rst_pin_oe_n_o)
    else $error("reset pin driven on pin reset");
  chk_pin_drive: assert property (
      HAS_RST_OUT && core_rst_o && kind != RSC_SRC_EXT |-> !rst_pin_oe_n_o)
    else $error("reset pin not driven on internal reset");
  chk_abandon_now: assert property ((wdt_ovf_i || sw_req || ext_lvl) |=> cpu_halt_o)
    else $error("cpu not halted on reset source");
  chk_fetch_order: assert property ($rose(state == RSC_FETCH) |-> $past(state) == RSC_CRW)
    else $error("mode fetch without oscillator wait");
  chk_fetch_req: assert property (state == RSC_FETCH |-> fetch_req_o && !core_rst_o)
    else $error("fetch request missing");
  chk_pon_hold: assert property (state == RSC_OSCW |-> core_rst_o)
    else $error("reset released during oscillation wait");
  chk_pin_async: assert property (!ext_rst_n_i |-> pins_hiz_o)
    else $error("pins not safe on pin reset");
  chk_hiz_keep: assert property (core_rst_o |=> pins_hiz_o)
    else $error("pins left high impedance early");
  chk_high_zero: assert property (ack_o |-> dat_o[7:5] == 3'h0)
    else $error("reserved cause bits nonzero");
  chk_read_clears: assert property (
      rd_cause && quiet && !lvd_sync && !sw_req |=> cause == 5'h00)
    else $error("cause not cleared by read");
  chk_hw_flag: assert property ($rose(cause[RSC_BIT_WDT]) |-> cause[RSC_BIT_HWR])
    else $error("hardware flag missing on watchdog reset");
  chk_filter_min: assert property ($rose(ext_lvl) |-> $past(!ext_sync, FILT_MIN))
    else $error("short pin low accepted");

  sequence s_init_entry;
    $rose(state == RSC_INIT);
  endsequence

  // A free-running divider would cut the first initial-rate cycle short
  chk_init_div_start: assert property (s_init_entry |-> div == 5'h00)
    else $error("initial rate divider not restarted");
  chk_sw_flag_set: assert property (ev_sw |=> cause[RSC_BIT_SWR])
    else $error("software flag not set");
  chk_sw_keeps_hw: assert property (ev_sw |=> $stable(cause[RSC_BIT_HWR]))
    else $error("hardware flag changed by software reset");
  chk_wdt_flag_set: assert property (
      ev_wdt |=> cause[RSC_BIT_WDT] && cause[RSC_BIT_HWR])
    else $error("watchdog flags not set");
  chk_pin_flag_set: assert property (
      ev_pin |=> cause[RSC_BIT_PIN] && cause[RSC_BIT_HWR])
    else $error("pin flags not set");
  chk_pon_flags: assert property (
      ev_pon |=> cause[RSC_BIT_PON] && cause[RSC_BIT_HWR] && !cause[RSC_BIT_SWR])
    else $error("power-on flags wrong");
  chk_wait_keep: assert property (
      !ev_pon && !(bus_req && we_i && adr_i == RSC_ADR_WAIT && sel_i[0]) |=> $stable(osc_wait_time_register))
    else $error("wait setting changed without power-on");

endmodule

// ---- verif/rsc_cpu_model.sv ----
// Behavioural CPU core that answers the mode fetch and then configures the pins
`timescale 1ns/1ps
module rsc_cpu_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic fetch_req_i,
  input  wire logic slow_i,
  output logic      fetch_done_o,
  output logic      pin_cfg_o
);
  logic [3:0] cnt;
  logic       fetched;
  logic [3:0] lat;
  assign lat = slow_i ? 4'h9 : 4'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt          <= 4'h0;
      fetched      <= 1'b0;
      fetch_done_o <= 1'b0;
      pin_cfg_o    <= 1'b0;
    end else begin
      // Fetch only once permitted; a slow core stretches the halt
      cnt          <= !fetch_req_i ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
      fetch_done_o <= fetch_req_i && (cnt == lat);
      fetched      <= (fetched || fetch_done_o) && !pin_cfg_o;
      // Pins set up by software only after release
      pin_cfg_o    <= fetched && !fetch_req_i && !pin_cfg_o;
    end
  end
endmodule

// ---- verif/reset_control_and_cause_tb.sv ----
// Self-checking bench of the reset sequencer and cause register
`timescale 1ns/1ps
module reset_control_and_cause_tb import rsc_pkg::*;;
  logic clk_i, rst_i, ext_rst_n_i, lvd_i, wdt_ovf_i, ram_busy_i, mclk_en_i, osc_stby_i;
  logic cyc_i, stb_i, we_i, ack_o, core_rst_o, cpu_halt_o, fetch_req_o, pins_hiz_o;
  logic rst_pin_o, rst_pin_oe_n_o, fetch_done, pin_cfg, slow, sub_stop;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o;
  logic [1:0]  mdiv;
  int          mismatches, compares;

  rsc_reset_ctrl #(.OSC_UNIT(2)) rsc_reset_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ext_rst_n_i(ext_rst_n_i), .lvd_i(lvd_i), .wdt_ovf_i(wdt_ovf_i), .ram_busy_i(ram_busy_i),
    .mclk_en_i(mclk_en_i), .osc_stby_i(osc_stby_i), .sub_stop_i(sub_stop),
    .fetch_done_i(fetch_done), .pin_cfg_i(pin_cfg), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .core_rst_o(core_rst_o), .cpu_halt_o(cpu_halt_o), .fetch_req_o(fetch_req_o),
    .pins_hiz_o(pins_hiz_o), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o));
  rsc_cpu_model rsc_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .fetch_req_i(fetch_req_o),
    .slow_i(slow), .fetch_done_o(fetch_done), .pin_cfg_o(pin_cfg));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Pre-reset machine clock runs at a quarter of the system clock
  always @(posedge clk_i) begin
    mdiv      <= rst_i ? 2'h0 : mdiv + 2'h1;
    mclk_en_i <= !rst_i && (mdiv == 2'h3);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    rd = dat_o;
    // Registered slave: ack seen at the second edge after the request
    chk(32'(n), 32'h2);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] v;
    wb(1'b1, a, d, v);
  endtask
  // Reset length, then the fixed settling wait before the fetch, then pin release
  task automatic wait_seq(input int lo, input int hi);
    int n;
    n = 0;
    while (core_rst_o !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(pins_hiz_o), 32'h1);
    n = 0;
    while (core_rst_o === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
      chk(32'(fetch_req_o), 32'h0);
    end
    chk_rng(n, lo, hi);
    n = 0;
    while (fetch_req_o !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    chk_rng(n, int'(RSC_CR_WAIT_CYC) - 1, int'(RSC_CR_WAIT_CYC) + 1);
    n = 0;
    while (cpu_halt_o !== 1'b0 && n < 30) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(cpu_halt_o), 32'h0);
    repeat (6) @(posedge clk_i);
    chk(32'(pins_hiz_o), 32'h0);
  endtask

  task automatic t_por;
    chk(32'(rst_pin_oe_n_o), 32'h0);
    rst_i <= 1'b0;
    wait_seq(31, 35);
    rd_chk(RSC_ADR_CAUSE, 32'h06);
    rd_chk(RSC_ADR_CAUSE, 32'h00);
    rd_chk(RSC_ADR_WAIT, 32'h0f);
    rd_chk(4'hc, 32'h0);
    rd_chk(RSC_ADR_STBY, 32'h0);
  endtask
  task automatic t_soft;
    wr(RSC_ADR_CAUSE, 32'hff);
    rd_chk(RSC_ADR_CAUSE, 32'h00);
    wr(RSC_ADR_WAIT, 32'h3);
    wr(RSC_ADR_STBY, 32'h1);
    @(posedge clk_i);
    chk(32'(cpu_halt_o), 32'h1);
    chk(32'(rst_pin_oe_n_o), 32'h0);
    chk(32'(rst_pin_o), 32'h0);
    wait_seq(64, 67);
    rd_chk(RSC_ADR_CAUSE, 32'h01);
    rd_chk(RSC_ADR_WAIT, 32'h3);
  endtask
  // Watchdog in oscillator standby, slow core: wait of (3+1)*2 added
  task automatic t_wdt;
    slow       <= 1'b1;
    osc_stby_i <= 1'b1;
    @(posedge clk_i);
    wdt_ovf_i <= 1'b1;
    @(posedge clk_i);
    wdt_ovf_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(cpu_halt_o), 32'h1);
    wait_seq(73, 76);
    rd_chk(RSC_ADR_CAUSE, 32'h0a);
    slow       <= 1'b0;
    osc_stby_i <= 1'b0;
  endtask
  // Pin reset released as from stop mode: oscillation wait of (3+1)*2 added
  task automatic t_pin;
    @(posedge clk_i);
    ext_rst_n_i <= 1'b0;
    sub_stop    <= 1'b1;
    #1 chk(32'(pins_hiz_o), 32'h1);
    repeat (12) begin
      @(posedge clk_i);
      chk(32'(rst_pin_oe_n_o), 32'h1);
    end
    chk(32'(core_rst_o), 32'h1);
    ext_rst_n_i <= 1'b1;
    wait_seq(75, 79);
    rd_chk(RSC_ADR_CAUSE, 32'h12);
    // Short glitch below the filter width
    ext_rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    ext_rst_n_i <= 1'b1;
    repeat (12) begin
      @(posedge clk_i);
      chk(32'(core_rst_o), 32'h0);
    end
    rd_chk(RSC_ADR_CAUSE, 32'h00);
    sub_stop <= 1'b0;
  endtask
  // Soft reset held off by a RAM word write, then low voltage clears the software flag
  task automatic t_ram_lvd;
    ram_busy_i <= 1'b1;
    wr(RSC_ADR_STBY, 32'h1);
    repeat (6) begin
      @(posedge clk_i);
      chk(32'(core_rst_o), 32'h0);
    end
    ram_busy_i <= 1'b0;
    wait_seq(66, 70);
    lvd_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    lvd_i <= 1'b0;
    wait_seq(31, 45);
    rd_chk(RSC_ADR_CAUSE, 32'h06);
    rd_chk(RSC_ADR_WAIT, 32'h0f);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #(25 * 30000);
    mismatches++;
    final_report();
  end
  initial begin
    {rst_i, ext_rst_n_i, lvd_i, wdt_ovf_i, ram_busy_i, osc_stby_i} = 6'b110000;
    {cyc_i, stb_i, we_i, slow, sub_stop} = 5'h0;
    adr_i = 4'h0;
    sel_i = 4'h1;
    dat_i = 32'h0;
    mismatches = 0;
    compares   = 0;
    repeat (16) @(posedge clk_i);
    t_por();
    t_soft();
    t_wdt();
    t_pin();
    t_ram_lvd();
    final_report();
  end
endmodule
